//--- sbg_pkg.sv
// Package: register map, field positions, reset values and shared types
package sbg_pkg;
   // Register byte addresses (one aligned word each)
   localparam logic [7:0] ADDR_BAUD_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_DIV_LOW = 8'h04;
   localparam logic [7:0] ADDR_DIV_HIGH = 8'h08;
   localparam logic [7:0] ADDR_MODE_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_RX_STATUS = 8'h10;
   // Baud control field positions
   localparam int BIT_AB_OVF = 7;
   localparam int BIT_RX_IDLE = 6;
   localparam int BIT_WIDE_DIV = 3;
   localparam int BIT_WAKEUP = 1;
   localparam int BIT_AB_EN = 0;
   // Mode control field positions
   localparam int BIT_SYNC = 0;
   localparam int BIT_HIGH_SPEED = 1;
   // Reset values
   localparam logic [7:0] RST_BAUD_CONTROL = 8'h40;
   localparam logic [15:0] RST_DIVISOR = 16'h0000;
   // Prescale counts (minus one) per mode
   localparam logic [5:0] PRE_64 = 6'h3F;
   localparam logic [5:0] PRE_16 = 6'h0F;
   localparam logic [5:0] PRE_4 = 6'h03;
   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Rate selection bits travelling together
   typedef struct packed {
      logic sync_mode;
      logic wide_div;
      logic high_speed;
   } sbg_mode_t;

   // Auto-baud measurement states, Gray along the path
   typedef enum logic [1:0] {
      AB_IDLE = 2'b00,
      AB_WAIT = 2'b01,
      AB_MEAS = 2'b11
   } sbg_ab_state_t;
endpackage

//--- sbg_timer.sv
// Baud timer: prescaler plus 8/16-bit reload counter producing a tick
`timescale 1ns/1ps
module sbg_timer #(
   parameter int DIV_W = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire sbg_pkg::sbg_mode_t i_mode,
   input wire logic [DIV_W-1:0] i_divisor,
   input wire logic i_clear,
   output logic o_tick
);
   logic [5:0] pre_r;
   logic [5:0] pre_nxt;
   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] cnt_nxt;
   logic tick_nxt;
   logic [5:0] pre_top;
   logic [DIV_W-1:0] reload;

   // Prescale choice: sync ignores high-speed, async uses both bits
   always_comb begin
      if (i_mode.sync_mode) begin
         pre_top = sbg_pkg::PRE_4;
      end else if (!i_mode.wide_div && !i_mode.high_speed) begin
         pre_top = sbg_pkg::PRE_64;
      end else if (i_mode.wide_div && i_mode.high_speed) begin
         pre_top = sbg_pkg::PRE_4;
      end else begin
         pre_top = sbg_pkg::PRE_16;
      end
      // 8-bit mode uses only the low byte
      reload = i_mode.wide_div ? i_divisor : {{(DIV_W-8){1'b0}}, i_divisor[7:0]};
   end

   // Down counter reloads with n, so period is pre*(n+1)
   always_comb begin
      pre_nxt = pre_r;
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (i_clear) begin
         pre_nxt = 6'h00;
         cnt_nxt = reload;
      end else if (pre_r >= pre_top) begin
         pre_nxt = 6'h00;
         if (cnt_r == '0) begin
            cnt_nxt = reload;
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - 1'b1;
         end
      end else begin
         pre_nxt = pre_r + 6'h01;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pre_r <= 6'h00;
         cnt_r <= '0;
         o_tick <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         cnt_r <= cnt_nxt;
         o_tick <= tick_nxt;
      end
   end
endmodule

//--- sbg_top.sv
// Baud rate generator top: AXI4-Lite registers, auto-baud, wake-up and idle
`timescale 1ns/1ps
// Contract
// - Timer is 8-bit, 16-bit when selected
// - Divisor byte pair sets timer period
// - Async multiplier from high-speed and wide bits
// - Sync mode ignores high-speed select
// - Divisor write clears timer immediately
// - 8-bit async low speed divides 64(n+1)
// - Bit 6 receiver idle flag, resets one
// - n is high:low in 16-bit mode, low byte alone in 8-bit; sync divides 4(n+1)
module sbg_top #(
   parameter int DIV_W = 16,
   parameter int AW = 8
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic [AW-1:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [AW-1:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   input wire logic I_RX_LINE,
   input wire logic I_RX_BUSY,
   input wire logic I_RX_DONE,
   output logic O_BAUD_TICK,
   output logic O_RX_WAKE_ARMED
);
   // Register state
   logic wide_r, wide_nxt, wake_r, wake_nxt, abd_en_r, abd_en_nxt;
   logic ovf_r, ovf_nxt, idle_r, idle_nxt, sync_r, sync_nxt;
   logic hs_r, hs_nxt, rcv_flag_r, rcv_flag_nxt;
   logic [DIV_W-1:0] div_r, div_nxt;
   logic div_wr, rx_q_r, tick;
   sbg_pkg::sbg_ab_state_t ab_r, ab_nxt;
   logic [DIV_W-1:0] ab_cnt_r, ab_cnt_nxt;
   logic [2:0] ab_edges_r, ab_edges_nxt;
   // Bus state
   logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
   logic [AW-1:0] awa_r, awa_nxt;
   logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
   logic [3:0] ws_r, ws_nxt;
   logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
   logic wr_go, rd_go, fall, awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, arrdy_r, arrdy_nxt;
   sbg_pkg::sbg_mode_t mode;

   assign mode = '{sync_mode: sync_r, wide_div: wide_r, high_speed: hs_r};
   assign fall = rx_q_r && !I_RX_LINE;

   sbg_timer #(.DIV_W(DIV_W)) u_timer (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_mode(mode),
      .i_divisor(div_nxt), // the clearing write reloads the new value
      .i_clear(div_wr),
      .o_tick(tick)
   );

   // Address decode shared by read and write paths
   function automatic logic is_mapped(input logic [AW-1:0] a);
      return a == sbg_pkg::ADDR_BAUD_CONTROL || a == sbg_pkg::ADDR_DIV_LOW ||
         a == sbg_pkg::ADDR_DIV_HIGH || a == sbg_pkg::ADDR_MODE_CTRL ||
         a == sbg_pkg::ADDR_RX_STATUS;
   endfunction

   // Write channel capture: address and data accepted in either order
   always_comb begin
      aw_nxt = aw_r;
      awa_nxt = awa_r;
      w_nxt = w_r;
      wd_nxt = wd_r;
      ws_nxt = ws_r;
      bv_nxt = bv_r;
      br_nxt = br_r;
      if (I_AWVALID && !aw_r && !bv_r) begin
         aw_nxt = 1'b1;
         awa_nxt = I_AWADDR;
      end
      if (I_WVALID && !w_r && !bv_r) begin
         w_nxt = 1'b1;
         wd_nxt = I_WDATA;
         ws_nxt = I_WSTRB;
      end
      if (wr_go) begin
         aw_nxt = 1'b0;
         w_nxt = 1'b0;
         bv_nxt = 1'b1;
         br_nxt = is_mapped(awa_r) ? sbg_pkg::RESP_OKAY : sbg_pkg::RESP_SLVERR;
      end else if (bv_r && I_BREADY) begin
         bv_nxt = 1'b0;
      end
      awrdy_nxt = !aw_nxt && !bv_nxt;
      wrdy_nxt = !w_nxt && !bv_nxt;
   end
   assign wr_go = aw_r && w_r && !bv_r;

   // Read channel: data registered one cycle after address
   always_comb begin
      rv_nxt = rv_r;
      rd_nxt = rd_r;
      rr_nxt = rr_r;
      if (rd_go) begin
         rv_nxt = 1'b1;
         rr_nxt = is_mapped(I_ARADDR) ? sbg_pkg::RESP_OKAY : sbg_pkg::RESP_SLVERR;
         unique case (I_ARADDR)
            sbg_pkg::ADDR_BAUD_CONTROL: rd_nxt = {24'h0, ovf_r, idle_r, 2'b00, wide_r,
               1'b0, wake_r, abd_en_r};
            sbg_pkg::ADDR_DIV_LOW: rd_nxt = {24'h0, div_r[7:0]};
            sbg_pkg::ADDR_DIV_HIGH: rd_nxt = {24'h0, div_r[DIV_W-1:8]};
            sbg_pkg::ADDR_MODE_CTRL: rd_nxt = {30'h0, hs_r, sync_r};
            sbg_pkg::ADDR_RX_STATUS: rd_nxt = {31'h0, rcv_flag_r};
            default: rd_nxt = 32'h0;
         endcase
      end else if (rv_r && I_RREADY) begin
         rv_nxt = 1'b0;
      end
      arrdy_nxt = !rv_nxt;
   end
   assign rd_go = I_ARVALID && !rv_r;

   // Register updates; hardware sets win over software clears
   always_comb begin
      wide_nxt = wide_r;
      wake_nxt = wake_r;
      abd_en_nxt = abd_en_r;
      ovf_nxt = ovf_r;
      sync_nxt = sync_r;
      hs_nxt = hs_r;
      div_nxt = div_r;
      rcv_flag_nxt = rcv_flag_r;
      div_wr = 1'b0;
      idle_nxt = sync_r ? 1'b1 : !I_RX_BUSY;
      if (wr_go && ws_r[0]) begin
         unique case (awa_r)
            sbg_pkg::ADDR_BAUD_CONTROL: begin
               wide_nxt = wd_r[sbg_pkg::BIT_WIDE_DIV];
               wake_nxt = wd_r[sbg_pkg::BIT_WAKEUP];
               abd_en_nxt = wd_r[sbg_pkg::BIT_AB_EN] && !sync_r;
               if (wd_r[sbg_pkg::BIT_AB_EN]) begin
                  ovf_nxt = 1'b0;
               end
            end
            sbg_pkg::ADDR_DIV_LOW: begin
               div_nxt[7:0] = wd_r[7:0];
               div_wr = 1'b1;
            end
            sbg_pkg::ADDR_DIV_HIGH: begin
               div_nxt[DIV_W-1:8] = wd_r[DIV_W-9:0];
               div_wr = 1'b1;
            end
            sbg_pkg::ADDR_MODE_CTRL: begin
               sync_nxt = wd_r[sbg_pkg::BIT_SYNC];
               hs_nxt = wd_r[sbg_pkg::BIT_HIGH_SPEED];
            end
            sbg_pkg::ADDR_RX_STATUS: rcv_flag_nxt = rcv_flag_r && !wd_r[0];
            default: ;
         endcase
      end
      // Received byte raises the flag and ends the wake-up wait
      if (I_RX_DONE) begin
         rcv_flag_nxt = 1'b1;
         wake_nxt = 1'b0;
      end
      if (ab_r == sbg_pkg::AB_MEAS && ab_edges_nxt == 3'h5) begin
         abd_en_nxt = 1'b0;
         div_nxt = ab_cnt_r;
      end
      if (ab_r == sbg_pkg::AB_MEAS && ab_cnt_r == '1) begin
         ovf_nxt = 1'b1;
         abd_en_nxt = 1'b0;
      end
   end

   // Auto-baud: count prescaled ticks from the first falling edge to the sixth
   always_comb begin
      ab_nxt = ab_r;
      ab_cnt_nxt = ab_cnt_r;
      ab_edges_nxt = ab_edges_r;
      unique case (ab_r)
         sbg_pkg::AB_IDLE: begin
            if (abd_en_r) begin
               ab_nxt = sbg_pkg::AB_WAIT;
            end
         end
         sbg_pkg::AB_WAIT: begin
            ab_cnt_nxt = '0;
            ab_edges_nxt = 3'h0;
            if (!abd_en_r) begin
               ab_nxt = sbg_pkg::AB_IDLE;
            end else if (fall) begin
               ab_nxt = sbg_pkg::AB_MEAS;
            end
         end
         sbg_pkg::AB_MEAS: begin
            if (tick && ab_cnt_r != '1) begin
               ab_cnt_nxt = ab_cnt_r + 1'b1;
            end
            if (fall) begin
               ab_edges_nxt = ab_edges_r + 3'h1;
            end
            if (ab_edges_nxt == 3'h5 || ab_cnt_r == '1 || !abd_en_r) begin
               ab_nxt = sbg_pkg::AB_IDLE;
            end
         end
         default: ab_nxt = sbg_pkg::AB_IDLE;
      endcase
   end

   // Registers; reset leaves 8-bit mode, idle flag high
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         wide_r <= 1'b0;
         wake_r <= 1'b0;
         abd_en_r <= 1'b0;
         ovf_r <= 1'b0;
         idle_r <= sbg_pkg::RST_BAUD_CONTROL[sbg_pkg::BIT_RX_IDLE];
         sync_r <= 1'b0;
         hs_r <= 1'b0;
         rcv_flag_r <= 1'b0;
         div_r <= sbg_pkg::RST_DIVISOR;
         rx_q_r <= 1'b1;
         ab_r <= sbg_pkg::AB_IDLE;
         ab_cnt_r <= '0;
         ab_edges_r <= 3'h0;
         aw_r <= 1'b0;
         awa_r <= '0;
         w_r <= 1'b0;
         wd_r <= 32'h0;
         ws_r <= 4'h0;
         bv_r <= 1'b0;
         br_r <= 2'h0;
         rv_r <= 1'b0;
         rd_r <= 32'h0;
         rr_r <= 2'h0;
         awrdy_r <= 1'b1;
         wrdy_r <= 1'b1;
         arrdy_r <= 1'b1;
      end else begin
         wide_r <= wide_nxt;
         wake_r <= wake_nxt;
         abd_en_r <= abd_en_nxt;
         ovf_r <= ovf_nxt;
         idle_r <= idle_nxt;
         sync_r <= sync_nxt;
         hs_r <= hs_nxt;
         rcv_flag_r <= rcv_flag_nxt;
         div_r <= div_nxt;
         rx_q_r <= I_RX_LINE;
         ab_r <= ab_nxt;
         ab_cnt_r <= ab_cnt_nxt;
         ab_edges_r <= ab_edges_nxt;
         aw_r <= aw_nxt;
         awa_r <= awa_nxt;
         w_r <= w_nxt;
         wd_r <= wd_nxt;
         ws_r <= ws_nxt;
         bv_r <= bv_nxt;
         br_r <= br_nxt;
         rv_r <= rv_nxt;
         rd_r <= rd_nxt;
         rr_r <= rr_nxt;
         awrdy_r <= awrdy_nxt;
         wrdy_r <= wrdy_nxt;
         arrdy_r <= arrdy_nxt;
      end
   end

   // Ready flags are registered states; ready is high while slot free
   assign O_AWREADY = awrdy_r;
   assign O_WREADY = wrdy_r;
   assign O_ARREADY = arrdy_r;
   assign O_BVALID = bv_r;
   assign O_BRESP = br_r;
   assign O_RVALID = rv_r;
   assign O_RDATA = rd_r;
   assign O_RRESP = rr_r;
   assign O_BAUD_TICK = tick;
   // Wake-up armed: receiver waits for falling edge while set
   assign O_RX_WAKE_ARMED = wake_r;
endmodule

//--- sbg_top_monitor.sv
// Checker on the top ports of the baud rate generator
`timescale 1ns/1ps
module sbg_top_monitor #(
   parameter int DIV_W = 16,
   parameter int AW = 8
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic [AW-1:0] I_AWADDR,
   input wire logic I_AWVALID,
   input wire logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   input wire logic O_WREADY,
   input wire logic [1:0] O_BRESP,
   input wire logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [AW-1:0] I_ARADDR,
   input wire logic I_ARVALID,
   input wire logic O_ARREADY,
   input wire logic [31:0] O_RDATA,
   input wire logic [1:0] O_RRESP,
   input wire logic O_RVALID,
   input wire logic I_RREADY,
   input wire logic I_RX_LINE,
   input wire logic I_RX_BUSY,
   input wire logic I_RX_DONE,
   input wire logic O_BAUD_TICK,
   input wire logic O_RX_WAKE_ARMED
);
   logic [AW-1:0] aw_r;
   logic [AW-1:0] aw_nxt;
   logic div_w;
   logic bad_w;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   // Remember the last accepted write address, the response refers to it
   always_comb begin
      aw_nxt = (I_AWVALID && O_AWREADY) ? I_AWADDR : aw_r;
   end
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         aw_r <= '0;
      end else begin
         aw_r <= aw_nxt;
      end
   end
   assign div_w = (aw_r == AW'(sbg_pkg::ADDR_DIV_LOW)) || (aw_r == AW'(sbg_pkg::ADDR_DIV_HIGH));
   assign bad_w = (aw_r > AW'(sbg_pkg::ADDR_RX_STATUS)) || (aw_r[1:0] != 2'h0);
   property p_tick_pulse;
      O_BAUD_TICK |=> !O_BAUD_TICK;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
   // The timer restarts, so no tick can come in the few cycles after the write
   property p_div_clear;
      $rose(O_BVALID) && div_w |=> !O_BAUD_TICK [*3];
   endproperty
   a_div_clear: assert property (p_div_clear) else $error("tick too soon after divisor write");
   property p_wake_clear;
      O_RX_WAKE_ARMED && I_RX_DONE |=> !O_RX_WAKE_ARMED;
   endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("wake-up did not clear");
   property p_wake_set;
      $rose(O_RX_WAKE_ARMED) |-> $rose(O_BVALID);
   endproperty
   a_wake_set: assert property (p_wake_set) else $error("wake-up set without a write");
   property p_b_after;
      I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:2] O_BVALID;
   endproperty
   a_b_after: assert property (p_b_after) else $error("write response missing");
   property p_r_after;
      I_ARVALID && O_ARREADY |=> O_RVALID;
   endproperty
   a_r_after: assert property (p_r_after) else $error("read data missing");
   property p_arready;
      O_ARREADY == !O_RVALID;
   endproperty
   a_arready: assert property (p_arready) else $error("read ready wrong");
   property p_b_block;
      O_BVALID |-> !O_AWREADY && !O_WREADY;
   endproperty
   a_b_block: assert property (p_b_block) else $error("write taken during response");
   property p_bresp;
      $rose(O_BVALID) |-> O_BRESP == (bad_w ? sbg_pkg::RESP_SLVERR : sbg_pkg::RESP_OKAY);
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response code wrong");
   c_tick: cover property (O_BAUD_TICK);
   c_wake: cover property (O_RX_WAKE_ARMED && I_RX_DONE);
   c_bad: cover property ($rose(O_BVALID) && bad_w);
endmodule
bind sbg_top sbg_top_monitor #(.DIV_W(DIV_W), .AW(AW)) u_mon (.*);

//--- sbg_top_tb_top.sv
// Self-checking bench for the baud rate generator
`timescale 1ns/1ps
module sbg_top_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdat, seed = 32'h0000D96A;
   logic [1:0] rsp;
   logic rx = 1'b1, busy = 1'b0, done = 1'b0;
   logic [3:0] ws = 4'hF;
   logic awr, wr_rdy, bv, arr, rv, tick, armed;
   logic [1:0] br, rr;
   logic [31:0] rd_o;
   logic [7:0] lo, hi;
   int errors = 0, num_checks = 0, m, c;
   sbg_top dut (.I_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(awa), .I_AWVALID(awv),
      .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws), .I_WVALID(wv), .O_WREADY(wr_rdy),
      .O_BRESP(br), .O_BVALID(bv), .I_BREADY(1'b1), .I_ARADDR(ara), .I_ARVALID(arv),
      .O_ARREADY(arr), .O_RDATA(rd_o), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(1'b1),
      .I_RX_LINE(rx), .I_RX_BUSY(busy), .I_RX_DONE(done), .O_BAUD_TICK(tick),
      .O_RX_WAKE_ARMED(armed));
   always #10 clk = ~clk;
   function automatic logic [31:0] xr();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected tick period in clocks for mode bits {sync, wide, high speed}
   function automatic int per(input logic [2:0] md, input logic [7:0] h, input logic [7:0] l);
      int p;
      p = md[2] ? 4 : (md[1:0] == 2'b00) ? 64 : (md[1:0] == 2'b11) ? 4 : 16;
      return p * ((md[1] ? int'({h, l}) : int'(l)) + 1);
   endfunction
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang();
      errors++;
      $display("ERROR t=%0t wait ran out", $time);
      summarize();
   endtask
   // Bus write: both halves offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(negedge clk);
         ta = awv && awr;
         tw = wv && wr_rdy;
         tb = bv;
         rsp = br;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tb) return;
      end
      hang();
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      ara <= a;
      arv <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(negedge clk);
         ta = arv && arr;
         tr = rv;
         rdat = rd_o;
         rsp = rr;
         @(posedge clk);
         if (ta) arv <= 1'b0;
         if (tr) return;
      end
      hang();
   endtask
   // Wait for a tick, sampled mid-cycle where outputs are settled
   task automatic wtick(output int cnt);
      cnt = 0;
      for (int n = 0; n < 40000; n++) begin
         @(negedge clk);
         cnt++;
         if (tick) return;
      end
      hang();
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(sbg_pkg::ADDR_BAUD_CONTROL);
      chk(rdat, {24'h0, sbg_pkg::RST_BAUD_CONTROL});
      rd(sbg_pkg::ADDR_DIV_HIGH);
      chk(rdat, 32'h0);
      wr(8'h14, 32'h000000FF);
      chk(32'(rsp), 32'(sbg_pkg::RESP_SLVERR));
      rd(8'h14);
      chk(rdat, 32'h0);
      chk(32'(rsp), 32'(sbg_pkg::RESP_SLVERR));
      // Flag bits ignore writes, only the wide select sticks
      wr(sbg_pkg::ADDR_BAUD_CONTROL, 32'h000000F8);
      rd(sbg_pkg::ADDR_BAUD_CONTROL);
      chk(rdat, 32'h00000048);
      // Lane 0 off: the write answers OKAY and leaves the register alone
      ws <= 4'h0;
      wr(sbg_pkg::ADDR_BAUD_CONTROL, 32'h00000002);
      chk(32'(rsp), 32'(sbg_pkg::RESP_OKAY));
      ws <= 4'hF;
      rd(sbg_pkg::ADDR_BAUD_CONTROL);
      chk(rdat, 32'h00000048);
      chk(32'(rsp), 32'(sbg_pkg::RESP_OKAY));
      $display("test reset and map done");
      // Every mode combination; the last one reaches the high byte
      for (m = 0; m < 8; m++) begin
         lo = 8'(xr() % 32);
         hi = 8'(xr() & 32'h1);
         if (m == 7) begin
            lo = 8'h00;
            hi = 8'h01;
         end
         wr(sbg_pkg::ADDR_MODE_CTRL, {30'h0, m[0], m[2]});
         wr(sbg_pkg::ADDR_BAUD_CONTROL, {28'h0, m[1], 3'h0});
         wr(sbg_pkg::ADDR_DIV_HIGH, {24'h0, hi});
         wr(sbg_pkg::ADDR_DIV_LOW, {24'h0, lo});
         // First period already runs at the new divisor
         wtick(c);
         chk(32'(c), 32'(per(m[2:0], hi, lo)));
         wtick(c);
         chk(32'(c), 32'(per(m[2:0], hi, lo)));
         @(posedge clk);
      end
      $display("test rates done");
      wr(sbg_pkg::ADDR_MODE_CTRL, 32'h0);
      wr(sbg_pkg::ADDR_BAUD_CONTROL, 32'h00000002);
      chk(32'(armed), 32'h1);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'(armed), 32'h0);
      rd(sbg_pkg::ADDR_RX_STATUS);
      chk(rdat, 32'h1);
      wr(sbg_pkg::ADDR_RX_STATUS, 32'h1);
      rd(sbg_pkg::ADDR_RX_STATUS);
      chk(rdat, 32'h0);
      $display("test wake-up done");
      busy <= 1'b1;
      repeat (3) @(posedge clk);
      rd(sbg_pkg::ADDR_BAUD_CONTROL);
      chk(rdat, 32'h0);
      wr(sbg_pkg::ADDR_MODE_CTRL, 32'h1);
      rd(sbg_pkg::ADDR_BAUD_CONTROL);
      chk(rdat, 32'h00000040);
      busy <= 1'b0;
      $display("test idle flag done");
      // Auto-baud: arm, then six falling edges complete a measurement
      wr(sbg_pkg::ADDR_MODE_CTRL, 32'h0);
      wr(sbg_pkg::ADDR_BAUD_CONTROL, 32'h00000001);
      rd(sbg_pkg::ADDR_BAUD_CONTROL);
      chk(rdat, 32'h00000041);
      for (m = 0; m < 6; m++) begin
         rx <= 1'b0;
         repeat (8) @(posedge clk);
         rx <= 1'b1;
         repeat (8) @(posedge clk);
      end
      rd(sbg_pkg::ADDR_BAUD_CONTROL);
      chk(rdat, 32'h00000040);
      $display("test auto-baud done");
      summarize();
   end
endmodule
